/* File: include/spf_pkg.sv */
// Constants, types and state layout of the self-programming flash control.
// Assumes one 50 MHz system clock and an 8-bit CPU I/O port for registers.
// Behaviour
// - Erase, write, lock-write last 3.7 to 4.5 ms
// - Bit 5 reserved, reads zero, writes ignored
// - Section busy bit 6 always reads zero
// - Ready irq requested while enable clear
// - No ready irq during EEPROM write or operation
// - Re-enable write clears whole temporary buffer
// - Lock/fuse read by load within three cycles
// - Page write command programs addressed page
// - Page write bit clears on completion or timeout
// - Core stalled during page erase and write
// - Page erase command erases addressed page
// - Page erase bit clears on completion or timeout
// - Enable arms store for four cycles only
// - Plain enable stores data pair in buffer
// - Enable clears after store, stays during operation
// - Only five listed low-field values take effect
// - EEPROM write blocks programming and fuse reads
// - Pointer selects fuse low, lock, ext, high
// - Programmed fuse bits read zero, unprogrammed one
package spf_pkg;
    localparam logic [5:0] REG_ADDR = 6'h37;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam int BIT_IE = 7;
    localparam int BIT_BUSY = 6;
    localparam int BIT_RSVD = 5;
    localparam int BIT_RWW = 4;
    localparam int BIT_BLB = 3;
    localparam int BIT_PGWR = 2;
    localparam int BIT_PGER = 1;
    localparam int BIT_SPEN = 0;
    localparam logic [4:0] CMD_RWW = 5'h11;
    localparam logic [4:0] CMD_BLB = 5'h09;
    localparam logic [4:0] CMD_PGWR = 5'h05;
    localparam logic [4:0] CMD_PGER = 5'h03;
    localparam logic [4:0] CMD_FILL = 5'h01;
    localparam logic [2:0] WIN_CYCLES = 3'h4;
    localparam logic [2:0] LPM_LAST = 3'h2;
    localparam int CLK_PERIOD_NS = 20;
    localparam int OP_MIN_NS = 3700000;
    localparam int OP_MAX_NS = 4500000;
    localparam int OP_CYCLES = (OP_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int OP_MAX_CYCLES = OP_MAX_NS / CLK_PERIOD_NS;
    localparam int TIMER_W = 20;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_ARMED = 3'b010,
        ST_BUSY = 3'b100
    } spf_fsm_t;

    typedef struct packed {
        spf_fsm_t fsm;
        logic [7:0] csr;
        logic [2:0] win;
        logic [TIMER_W-1:0] timer;
        logic stall;
        logic irq;
        logic erase;
        logic page_wr;
        logic buf_wr;
        logic buf_clear;
        logic [14:0] addr;
        logic [15:0] data;
        logic lpm_hit;
        logic [7:0] lpm_data;
    } spf_state_t;
endpackage

/* File: logic/spf_flash_ctl.sv */
// Self-programming control register and sequencer for program flash.
// Assumes the core pulses store/load strobes for one cycle, holds the
// pointer and data pair stable with them, and obeys the stall output.
`timescale 1ns/1ps
`default_nettype none
module spf_flash_ctl #(
    parameter int OP_CYCLES = spf_pkg::OP_CYCLES
) (
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic [5:0] io_addr,
    input wire logic io_wr,
    input wire logic [7:0] io_wdata,
    input wire logic spm_exec,
    input wire logic lpm_exec,
    input wire logic [15:0] z_ptr,
    input wire logic [15:0] write_data_pair,
    input wire logic eeprom_write_busy,
    input wire logic global_irq_enable,
    input wire logic [7:0] fuse_low,
    input wire logic [7:0] fuse_high,
    input wire logic [7:0] fuse_ext,
    input wire logic [7:0] lock_bits,
    output logic [7:0] ctl_status,
    output logic cpu_stall,
    output logic ready_irq,
    output logic flash_erase,
    output logic flash_page_write,
    output logic buf_write,
    output logic buf_clear,
    output logic [14:0] flash_addr,
    output logic [15:0] buf_data,
    output logic lpm_hit,
    output logic [7:0] lpm_data
);
    spf_pkg::spf_state_t s;
    spf_pkg::spf_state_t next_s;
    logic wr;

    localparam logic [spf_pkg::TIMER_W-1:0] OP_LOAD =
        spf_pkg::TIMER_W'(OP_CYCLES - 1);

    function automatic logic cmd_ok(input logic [4:0] c);
        cmd_ok = (c == spf_pkg::CMD_RWW) || (c == spf_pkg::CMD_BLB) ||
                 (c == spf_pkg::CMD_PGWR) || (c == spf_pkg::CMD_PGER) ||
                 (c == spf_pkg::CMD_FILL);
    endfunction

    function automatic logic [7:0] fuse_sel(input logic [1:0] z,
                                            input logic [7:0] lo,
                                            input logic [7:0] lk,
                                            input logic [7:0] ex,
                                            input logic [7:0] hi);
        case (z)
            2'h0: fuse_sel = lo;
            2'h1: fuse_sel = lk;
            2'h2: fuse_sel = ex;
            default: fuse_sel = hi;
        endcase
    endfunction

    // EEPROM write locks out the register entirely
    assign wr = io_wr && (io_addr == spf_pkg::REG_ADDR) && !eeprom_write_busy;

    always_comb begin
        next_s = s;
        next_s.erase = 1'b0;
        next_s.page_wr = 1'b0;
        next_s.buf_wr = 1'b0;
        next_s.buf_clear = 1'b0;
        next_s.lpm_hit = 1'b0;
        case (s.fsm)
            spf_pkg::ST_IDLE: begin
                if (wr) begin
                    next_s.csr[spf_pkg::BIT_IE] = io_wdata[spf_pkg::BIT_IE];
                    // Other low-field values are dropped
                    if (cmd_ok(io_wdata[4:0])) begin
                        next_s.csr[4:0] = io_wdata[4:0];
                        next_s.win = spf_pkg::WIN_CYCLES;
                        next_s.fsm = spf_pkg::ST_ARMED;
                        next_s.buf_clear = io_wdata[spf_pkg::BIT_RWW];
                    end
                end
            end
            spf_pkg::ST_ARMED: begin
                if (spm_exec && !eeprom_write_busy) begin
                    next_s.addr = z_ptr[15:1];
                    case (s.csr[4:0])
                        // Lock-bit write is timed like erase and write
                        spf_pkg::CMD_PGER, spf_pkg::CMD_PGWR, spf_pkg::CMD_BLB: begin
                            // Enable stays set until the timer ends
                            next_s.erase = s.csr[spf_pkg::BIT_PGER];
                            next_s.page_wr = s.csr[spf_pkg::BIT_PGWR];
                            next_s.stall = 1'b1;
                            next_s.timer = OP_LOAD;
                            next_s.fsm = spf_pkg::ST_BUSY;
                        end
                        spf_pkg::CMD_FILL: begin
                            // Pointer bit 0 dropped by the word address
                            next_s.buf_wr = 1'b1;
                            next_s.data = write_data_pair;
                            next_s.csr[4:0] = 5'h00;
                            next_s.fsm = spf_pkg::ST_IDLE;
                        end
                        default: begin
                            next_s.csr[4:0] = 5'h00;
                            next_s.fsm = spf_pkg::ST_IDLE;
                        end
                    endcase
                end else if (lpm_exec && !eeprom_write_busy &&
                             s.csr[spf_pkg::BIT_BLB] && s.win >= spf_pkg::LPM_LAST) begin
                    // Fuse inputs carry programmed as zero
                    next_s.lpm_data = fuse_sel(z_ptr[1:0], fuse_low, lock_bits,
                                               fuse_ext, fuse_high);
                    next_s.lpm_hit = 1'b1;
                    next_s.csr[4:0] = 5'h00;
                    next_s.fsm = spf_pkg::ST_IDLE;
                end else if (wr) begin
                    next_s.csr[spf_pkg::BIT_IE] = io_wdata[spf_pkg::BIT_IE];
                    if (cmd_ok(io_wdata[4:0])) begin
                        next_s.csr[4:0] = io_wdata[4:0];
                        next_s.win = spf_pkg::WIN_CYCLES;
                        next_s.buf_clear = io_wdata[spf_pkg::BIT_RWW];
                    end
                end else if (s.win == 3'h1) begin
                    // Expiry drops every command bit at once
                    next_s.csr[4:0] = 5'h00;
                    next_s.fsm = spf_pkg::ST_IDLE;
                end else begin
                    next_s.win = s.win - 3'h1;
                end
            end
            spf_pkg::ST_BUSY: begin
                // Only the interrupt enable may change mid-operation
                if (wr) begin
                    next_s.csr[spf_pkg::BIT_IE] = io_wdata[spf_pkg::BIT_IE];
                end
                if (s.timer == '0) begin
                    next_s.csr[4:0] = 5'h00;
                    next_s.stall = 1'b0;
                    next_s.fsm = spf_pkg::ST_IDLE;
                end else begin
                    next_s.timer = s.timer - 1'b1;
                end
            end
            default: begin
                next_s.fsm = spf_pkg::ST_IDLE;
                next_s.csr[4:0] = 5'h00;
                next_s.stall = 1'b0;
            end
        endcase
        // No read-while-write here, so both bits are tied low
        next_s.csr[spf_pkg::BIT_BUSY] = 1'b0;
        next_s.csr[spf_pkg::BIT_RSVD] = 1'b0;
        next_s.irq = next_s.csr[spf_pkg::BIT_IE] && global_irq_enable &&
                     !next_s.csr[spf_pkg::BIT_SPEN] && !eeprom_write_busy &&
                     (next_s.fsm != spf_pkg::ST_BUSY);
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            s <= '{fsm: spf_pkg::ST_IDLE, csr: spf_pkg::REG_RESET, default: '0};
        end else begin
            s <= next_s;
        end
    end

    assign ctl_status = s.csr;
    assign cpu_stall = s.stall;
    assign ready_irq = s.irq;
    assign flash_erase = s.erase;
    assign flash_page_write = s.page_wr;
    assign buf_write = s.buf_wr;
    assign buf_clear = s.buf_clear;
    assign flash_addr = s.addr;
    assign buf_data = s.data;
    assign lpm_hit = s.lpm_hit;
    assign lpm_data = s.lpm_data;

    // Helper: length of each stall episode
    logic [spf_pkg::TIMER_W-1:0] stall_len;
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            stall_len <= '0;
        end else if (s.stall) begin
            stall_len <= stall_len + 1'b1;
        end else begin
            stall_len <= '0;
        end
    end

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!arst_n);

    chk_rsvd_zero: assert property (ctl_status[6:5] == 2'h0)
        else $error("reserved or busy bit read as one");

    // Counter is sampled before its clear, so it holds the full length here
    chk_op_length: assert property ($fell(cpu_stall) |->
            stall_len == spf_pkg::TIMER_W'(OP_CYCLES))
        else $error("operation length differs from programming time");

    chk_op_bound: assert property (stall_len <= spf_pkg::TIMER_W'(OP_CYCLES))
        else $error("operation runs past programming time");

    chk_stall_busy: assert property (cpu_stall |->
            ctl_status[spf_pkg::BIT_SPEN] && !ready_irq)
        else $error("stall without enable or with ready irq");

    chk_stall_hold: assert property ((cpu_stall && s.timer != '0) |=>
            cpu_stall)
        else $error("stall dropped before timer end");

    chk_stall_start: assert property ($rose(cpu_stall) |->
            $past(s.fsm) == spf_pkg::ST_ARMED && $past(spm_exec))
        else $error("stall rose without an accepted store");

    chk_timer_end: assert property ((s.fsm == spf_pkg::ST_BUSY && s.timer == '0) |=>
            !cpu_stall && ctl_status[4:0] == 5'h00)
        else $error("operation end did not clear command");

    chk_busy_bits: assert property ((s.fsm == spf_pkg::ST_BUSY && s.timer != '0) |=>
            ctl_status[4:0] == $past(ctl_status[4:0]))
        else $error("command bits changed mid-operation");

    chk_irq_idle: assert property ((s.fsm == spf_pkg::ST_IDLE &&
            s.csr[spf_pkg::BIT_IE] && global_irq_enable && !eeprom_write_busy &&
            !wr)[*2] |-> ready_irq)
        else $error("ready irq missing while idle");

    chk_irq_spen: assert property (ready_irq |-> !ctl_status[spf_pkg::BIT_SPEN])
        else $error("ready irq while enable set");

    chk_irq_eeprom: assert property (eeprom_write_busy |=> !ready_irq)
        else $error("ready irq during EEPROM write");

    chk_ie_written: assert property ((wr &&
            !(s.fsm == spf_pkg::ST_ARMED && (spm_exec || lpm_exec))) |=>
            ctl_status[spf_pkg::BIT_IE] == $past(io_wdata[spf_pkg::BIT_IE]))
        else $error("interrupt enable not stored");

    chk_erase_go: assert property ((s.fsm == spf_pkg::ST_ARMED && spm_exec &&
            !eeprom_write_busy && s.csr[4:0] == spf_pkg::CMD_PGER) |=>
            flash_erase && cpu_stall && flash_addr == $past(z_ptr[15:1]))
        else $error("page erase not started");

    chk_erase_pulse: assert property (flash_erase |=> !flash_erase)
        else $error("erase pulse longer than one cycle");

    chk_write_go: assert property ((s.fsm == spf_pkg::ST_ARMED && spm_exec &&
            !eeprom_write_busy && s.csr[4:0] == spf_pkg::CMD_PGWR) |=>
            flash_page_write && !flash_erase && cpu_stall)
        else $error("page write not started");

    chk_write_addr: assert property ((s.fsm == spf_pkg::ST_ARMED && spm_exec &&
            !eeprom_write_busy && s.csr[4:0] == spf_pkg::CMD_PGWR) |=>
            flash_addr == $past(z_ptr[15:1]))
        else $error("page write address wrong");

    chk_write_pulse: assert property (flash_page_write |=> !flash_page_write)
        else $error("write pulse longer than one cycle");

    chk_fill_word: assert property ((s.fsm == spf_pkg::ST_ARMED && spm_exec &&
            !eeprom_write_busy && s.csr[4:0] == spf_pkg::CMD_FILL) |=>
            buf_write && buf_data == $past(write_data_pair) &&
            ctl_status[4:0] == 5'h00)
        else $error("buffer fill mishandled");

    chk_fill_addr: assert property ((s.fsm == spf_pkg::ST_ARMED && spm_exec &&
            !eeprom_write_busy && s.csr[4:0] == spf_pkg::CMD_FILL) |=>
            flash_addr == $past(z_ptr[15:1]))
        else $error("buffer word address wrong");

    chk_win_expiry: assert property ((s.fsm == spf_pkg::ST_ARMED && s.win == 3'h1 &&
            !spm_exec && !lpm_exec && !wr) |=> ctl_status[4:0] == 5'h00)
        else $error("arming window did not expire");

    chk_win_reload: assert property ((wr && cmd_ok(io_wdata[4:0]) &&
            s.fsm != spf_pkg::ST_BUSY &&
            !(s.fsm == spf_pkg::ST_ARMED && (spm_exec || lpm_exec))) |=>
            s.win == spf_pkg::WIN_CYCLES)
        else $error("window not reloaded by write");

    chk_win_range: assert property (s.fsm == spf_pkg::ST_ARMED |->
            s.win != 3'h0 && s.win <= spf_pkg::WIN_CYCLES)
        else $error("window count out of range");

    chk_armed_spen: assert property (s.fsm == spf_pkg::ST_ARMED |->
            ctl_status[spf_pkg::BIT_SPEN])
        else $error("armed without enable bit");

    chk_idle_clear: assert property (s.fsm == spf_pkg::ST_IDLE |->
            ctl_status[4:0] == 5'h00)
        else $error("command bits left set while idle");

    chk_spm_idle: assert property ((s.fsm == spf_pkg::ST_IDLE && spm_exec) |=>
            !(flash_erase || flash_page_write || buf_write || cpu_stall))
        else $error("store outside window took effect");

    chk_cmd_filter: assert property ((wr && s.fsm == spf_pkg::ST_IDLE &&
            !cmd_ok(io_wdata[4:0])) |=> ctl_status[4:0] == 5'h00)
        else $error("invalid command took effect");

    chk_buf_clear: assert property ((wr && s.fsm != spf_pkg::ST_BUSY &&
            io_wdata[4:0] == spf_pkg::CMD_RWW) |=> buf_clear)
        else $error("buffer clear missing");

    chk_ee_block: assert property (eeprom_write_busy |=>
            !(flash_erase || flash_page_write || buf_write || lpm_hit))
        else $error("action during EEPROM write");

    chk_lpm_late: assert property ((s.fsm == spf_pkg::ST_ARMED && lpm_exec &&
            !spm_exec && s.csr[spf_pkg::BIT_BLB] && s.win < spf_pkg::LPM_LAST) |=>
            !lpm_hit)
        else $error("late load returned fuse data");

    chk_lpm_done: assert property (lpm_hit |-> ctl_status[4:0] == 5'h00)
        else $error("read select not cleared after load");

    chk_lock_sel: assert property ((lpm_hit && $past(z_ptr[1:0]) == 2'h1) |->
            lpm_data == $past(lock_bits))
        else $error("lock bits not returned");

    chk_fuse_low: assert property ((lpm_hit && $past(z_ptr[1:0]) == 2'h0) |->
            lpm_data == $past(fuse_low))
        else $error("fuse low byte not returned");

    chk_fuse_ext: assert property ((lpm_hit && $past(z_ptr[1:0]) == 2'h2) |->
            lpm_data == $past(fuse_ext))
        else $error("extended fuse byte not returned");

    chk_fuse_high: assert property ((lpm_hit && $past(z_ptr[1:0]) == 2'h3) |->
            lpm_data == $past(fuse_high))
        else $error("fuse high byte not returned");

    cov_erase: cover property (flash_erase ##1 cpu_stall ##[1:1000] !cpu_stall);
    cov_lock_write: cover property ($rose(cpu_stall) && !flash_erase && !flash_page_write);
    cov_fill: cover property (buf_write);
    cov_lpm: cover property (lpm_hit);
    cov_expire: cover property (s.fsm == spf_pkg::ST_ARMED ##4 s.fsm == spf_pkg::ST_IDLE);
endmodule
`default_nettype wire

/* File: verification/spf_core_model.sv */
// Core-side model: register writes and store/load strobes to the controller.
// Assumes the controller samples on rising sys_clk; this model drives on falling.
`timescale 1ns/1ps
`default_nettype none
module spf_core_model (
    input wire logic sys_clk,
    input wire logic cpu_stall,
    input wire logic [7:0] ctl_status,
    output var logic [5:0] io_addr,
    output var logic io_wr,
    output var logic [7:0] io_wdata,
    output var logic spm_exec,
    output var logic lpm_exec,
    output var logic [15:0] z_ptr,
    output var logic [15:0] write_data_pair
);
    int stuck = 0;

    initial begin
        io_addr = 6'h00;
        io_wr = 1'b0;
        io_wdata = 8'h00;
        spm_exec = 1'b0;
        lpm_exec = 1'b0;
        z_ptr = 16'h0000;
        write_data_pair = 16'h0000;
    end

    // Halted core issues nothing; busy flag polled even though it reads zero
    task automatic wait_idle;
        for (int n = 0; n < 64 && (cpu_stall !== 1'b0 || ctl_status[6] !== 1'b0); n++) begin
            @(negedge sys_clk);
        end
        if (cpu_stall !== 1'b0 || ctl_status[6] !== 1'b0) begin
            stuck++;
            $display("Error at %0t: core wait ran out", $time);
        end
    endtask

    // Called at a falling edge; returns at the falling edge after the write
    task automatic reg_write(input logic [7:0] val);
        wait_idle();
        io_addr = spf_pkg::REG_ADDR;
        io_wdata = val;
        io_wr = 1'b1;
        @(negedge sys_clk);
        io_wr = 1'b0;
        io_addr = ~spf_pkg::REG_ADDR;
        io_wdata = ~val;
    endtask

    // Gap of 0..3 idle cycles lands a store strobe inside the arming window, 0..2 a load strobe
    task automatic cmd_seq(input logic [7:0] val, input int gap, input logic load,
                           input logic [15:0] z, input logic [15:0] d);
        z_ptr = z;
        write_data_pair = d;
        reg_write(val);
        repeat (gap) @(negedge sys_clk);
        spm_exec = ~load;
        lpm_exec = load;
        @(negedge sys_clk);
        spm_exec = 1'b0;
        lpm_exec = 1'b0;
        z_ptr = ~z;
        write_data_pair = ~d;
    endtask
endmodule
`default_nettype wire

/* File: verification/spf_flash_ctl_test.sv */
// Self-checking bench for the self-programming flash control.
// Assumes spf_core_model plays the core; fuse inputs are fixed patterns.
`timescale 1ns/1ps
`default_nettype none
module spf_flash_ctl_test;
    // Short operation time keeps the run brief
    localparam int OPC = 16;
    localparam logic [7:0] FUSE [4] = '{8'h62, 8'hfc, 8'hfd, 8'hd9};
    logic sys_clk, arst_n, eeprom_write_busy, global_irq_enable;
    logic [5:0] io_addr;
    logic io_wr, spm_exec, lpm_exec, cpu_stall, ready_irq, flash_erase, flash_page_write;
    logic buf_write, buf_clear, lpm_hit;
    logic [7:0] io_wdata, ctl_status, lpm_data;
    logic [15:0] z_ptr, write_data_pair, buf_data;
    logic [14:0] flash_addr;
    int failures = 0;
    int num_checks = 0;
    int n_clr = 0;

    spf_flash_ctl #(.OP_CYCLES(OPC)) i_spf_flash_ctl (.sys_clk(sys_clk), .arst_n(arst_n),
        .io_addr(io_addr), .io_wr(io_wr), .io_wdata(io_wdata), .spm_exec(spm_exec),
        .lpm_exec(lpm_exec), .z_ptr(z_ptr), .write_data_pair(write_data_pair),
        .eeprom_write_busy(eeprom_write_busy), .global_irq_enable(global_irq_enable),
        .fuse_low(FUSE[0]), .fuse_high(FUSE[3]), .fuse_ext(FUSE[2]), .lock_bits(FUSE[1]),
        .ctl_status(ctl_status), .cpu_stall(cpu_stall), .ready_irq(ready_irq),
        .flash_erase(flash_erase), .flash_page_write(flash_page_write), .buf_write(buf_write),
        .buf_clear(buf_clear), .flash_addr(flash_addr), .buf_data(buf_data),
        .lpm_hit(lpm_hit), .lpm_data(lpm_data));
    spf_core_model i_spf_core_model (.sys_clk(sys_clk), .cpu_stall(cpu_stall),
        .ctl_status(ctl_status), .io_addr(io_addr), .io_wr(io_wr), .io_wdata(io_wdata),
        .spm_exec(spm_exec), .lpm_exec(lpm_exec), .z_ptr(z_ptr),
        .write_data_pair(write_data_pair));

    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end

    always @(posedge sys_clk) begin
        if (buf_clear === 1'b1) n_clr++;
    end

    task automatic results;
        failures += i_spf_core_model.stuck;
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic t_invalid_irq;
        global_irq_enable = 1'b1;
        i_spf_core_model.reg_write(8'h07);
        check(ctl_status, 8'h00);
        i_spf_core_model.reg_write(8'hff);
        check(ctl_status, 8'h80);
        @(negedge sys_clk);
        check(ready_irq, 1'b1);
    endtask

    task automatic t_eeprom;
        eeprom_write_busy = 1'b1;
        repeat (2) @(negedge sys_clk);
        check(ready_irq, 1'b0);
        i_spf_core_model.cmd_seq(8'h01, 0, 1'b0, 16'h0010, 16'h1111);
        check({buf_write, ctl_status}, 9'h080);
        eeprom_write_busy = 1'b0;
    endtask

    task automatic t_long_op(input logic [7:0] cmd, input logic [15:0] z, input logic ers);
        int len;
        i_spf_core_model.cmd_seq(cmd, 1, 1'b0, z, 16'hffff);
        check({flash_erase, flash_page_write}, {ers, ~ers});
        check(flash_addr, z[15:1]);
        for (len = 0; len < 200 && cpu_stall === 1'b1; len++) begin
            check({ready_irq, ctl_status[0]}, 2'b01);
            @(negedge sys_clk);
        end
        check(len, OPC);
        check(ctl_status, cmd & 8'h80);
        @(negedge sys_clk);
        check(ready_irq, cmd[7]);
    endtask

    task automatic t_fill_boundary;
        i_spf_core_model.cmd_seq(8'h01, 3, 1'b0, 16'h0123, 16'hbeef);
        check(buf_write, 1'b1);
        check({flash_addr, 1'b0}, 16'h0122);
        check(buf_data, 16'hbeef);
        check(ctl_status, 8'h00);
    endtask

    task automatic t_rww_clear;
        int c0;
        c0 = n_clr;
        i_spf_core_model.reg_write(8'h11);
        repeat (3) @(negedge sys_clk);
        check(n_clr - c0, 1);
    endtask

    // Strobe one cycle past the window must be ignored
    task automatic t_timeout;
        i_spf_core_model.cmd_seq(8'h05, 4, 1'b0, 16'h0200, 16'h0000);
        check(ctl_status, 8'h00);
        check({cpu_stall, flash_page_write}, 2'b00);
    endtask

    task automatic t_fuse_read;
        for (int i = 0; i < 4; i++) begin
            i_spf_core_model.cmd_seq(8'h09, (i == 3) ? 2 : 0, 1'b1, 16'(i), 16'h0000);
            check({lpm_hit, lpm_data}, {1'b1, FUSE[i]});
        end
        i_spf_core_model.cmd_seq(8'h09, 3, 1'b1, 16'h0001, 16'h0000);
        check(lpm_hit, 1'b0);
    endtask

    // Store after read select writes lock bits, a timed operation
    task automatic t_lock_write;
        int len;
        i_spf_core_model.cmd_seq(8'h09, 0, 1'b0, 16'h0001, 16'h00fc);
        check({cpu_stall, flash_erase, flash_page_write}, 3'b100);
        for (len = 0; len < 200 && cpu_stall === 1'b1; len++) begin
            @(negedge sys_clk);
        end
        check(len, OPC);
        check(ctl_status, 8'h00);
    endtask

    initial begin
        arst_n = 1'b0;
        eeprom_write_busy = 1'b0;
        global_irq_enable = 1'b0;
        repeat (12) @(negedge sys_clk);
        arst_n = 1'b1;
        @(negedge sys_clk);
        check({cpu_stall, ready_irq, ctl_status}, 10'h000);
        t_invalid_irq();
        t_eeprom();
        t_long_op(8'h83, 16'h1234, 1'b1);
        t_fill_boundary();
        t_rww_clear();
        t_long_op(8'h05, 16'h0442, 1'b0);
        t_timeout();
        t_fuse_read();
        t_lock_write();
        results();
    end

    initial begin
        repeat (20000) @(posedge sys_clk);
        failures++;
        $display("Error at %0t: run did not finish", $time);
        results();
    end
endmodule
`default_nettype wire
